/* rtl/bsle_pkg.sv */
// Constants, register map and carrier types of the bridge status encoder.
//
// Contract
// RQ1: The yellow lamp reports status as a burst of one to eleven blinks.
// RQ2: Bursts are separated by a two second dark gap.
// RQ3: With several conditions active the larger blink count is shown.
// RQ4: One blink means the system is healthy with nothing else pending.
// RQ5: Two blinks mean the learned station table is empty.
// RQ6: Three blinks mean the base unit drops its clear to send or carrier.
// RQ7: Four blinks mean the frame buffer is saturated.
// RQ8: Wide area oversize, misaligned, aborted, bad CRC give five to eight.
// RQ9: Local oversize, misaligned and bad CRC frames give nine to eleven.
// RQ10: A code stops only after eight showings and its condition gone.
// RQ11: The green link lamp is lit exactly while link integrity is good.
// RQ12: The line port sends and receives AMI coded data at 64 kbps.
// RQ13: Blinks are equal on and off times from a free running tick.
package bsle_pkg;

	////////////////////////////////////////////////////////////////////////
	localparam int CLK_HZ  = 25_000_000;
	localparam int CLK_NS  = 40;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
	localparam int BLINK_ON_MS  = 250;
	localparam int BLINK_OFF_MS = 250;
	localparam int GAP_MS       = 2000;
	localparam logic [7:0] ON_TICKS  = 8'(BLINK_ON_MS / TICK_MS);
	localparam logic [7:0] OFF_TICKS = 8'(BLINK_OFF_MS / TICK_MS);
	localparam logic [7:0] GAP_TICKS = 8'(GAP_MS / TICK_MS);
	localparam int LINE_BPS   = 64000;
	localparam int BIT_NS     = 1_000_000_000 / LINE_BPS;
	localparam int BIT_CYCLES = BIT_NS / CLK_NS;

	////////////////////////////////////////////////////////////////////////
	localparam logic [3:0] CODE_OK      = 4'h1;
	localparam logic [3:0] CODE_LOWEST  = 4'h2;
	localparam logic [3:0] CODE_HIGHEST = 4'hb;
	localparam logic [3:0] SHOW_REPEATS = 4'h8;

	////////////////////////////////////////////////////////////////////////
	localparam int ADDR_W = 12;
	localparam logic [11:0] ADDR_CTRL     = 12'h000;
	localparam logic [11:0] ADDR_STATUS   = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
	localparam int CTRL_LED_EN_BIT  = 0;
	localparam int CTRL_LINE_EN_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h3;
	localparam int STAT_CODE_LSB = 0;
	localparam int STAT_LINK_BIT = 4;
	localparam int STAT_PEND_LSB = 8;
	localparam int IRQ_W = 10;
	localparam int IRQ_FRAME_LSB = 0;
	localparam int IRQ_BUF_BIT   = 7;
	localparam int IRQ_LINK_BIT  = 8;
	localparam int IRQ_BPV_BIT   = 9;
	localparam logic [9:0] IRQ_MASK_RST = 10'h000;

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} bsle_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} bsle_apb_rsp_type;

	// Levels: mac_empty, buf_sat. All frame errors are one-cycle pulses.
	typedef struct packed {
		logic mac_empty;
		logic buf_sat;
		logic wan_oversize;
		logic wan_misalign;
		logic wan_abort;
		logic wan_bad_crc;
		logic lan_oversize;
		logic lan_misalign;
		logic lan_bad_crc;
	} bsle_cond_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ON   = 2'b01,
		ST_OFF  = 2'b10,
		ST_GAP  = 2'b11
	} bsle_blink_type;

endpackage

/* rtl/bsle_tick.sv */
// Free running prescaler that emits a one-cycle tick every DIV clocks.
`timescale 1ns/1ps
`default_nettype none
module bsle_tick #(
	parameter int unsigned DIV = 250000
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Tick out.
	output var  logic tick
);
	import bsle_pkg::*;

	// The prescaler counts in 24 bits.
	if (DIV < 2 || DIV > 32'h00ffffff)
	begin : g_div_check
		$error("bsle_tick: DIV out of range");
	end

	typedef struct packed {
		logic [23:0] cnt;
		logic        tick;
	} bsle_tick_st_type;

	bsle_tick_st_type q, d;

	always_comb
	begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt == 24'(DIV - 1))
		begin
			d.cnt = 24'h000000;
			d.tick = 1'b1;
		end
		else
			d.cnt = q.cnt + 24'h000001;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign tick = q.tick;
endmodule // bsle_tick
`default_nettype wire

/* rtl/bsle_ami.sv */
// AMI line coder and decoder for the co-directional 64 kbps line port.
`timescale 1ns/1ps
`default_nettype none
module bsle_ami (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Bit timing and enable.
	input  wire logic bit_tick,
	input  wire logic enable,
	// User side.
	input  wire logic tx_bit,
	output var  logic tx_take,
	output var  logic rx_bit,
	output var  logic rx_valid,
	output var  logic bpv,
	// Line pins.
	input  wire logic rx_pos_pin,
	input  wire logic rx_neg_pin,
	output var  logic line_pos,
	output var  logic line_neg
);
	import bsle_pkg::*;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic       tx_pol;
		logic       pos;
		logic       neg;
		logic       marked;
		logic       rx_pol;
		logic       rx_bit;
		logic       rx_valid;
		logic       bpv;
	} bsle_ami_st_type;

	bsle_ami_st_type q, d;

	logic mark_p;
	logic mark_n;

	always_comb
	begin
		d = q;
		d.s1 = {rx_pos_pin, rx_neg_pin};
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.rx_valid = 1'b0;
		d.bpv = 1'b0;
		// Marks are judged once, at their leading edge, so a mark that
		// straddles a local bit boundary is not taken for two. Two marks of
		// one polarity with no space between them look like one long mark
		// and go unnoticed.
		mark_p = q.s2[1] & ~q.s3[1];
		mark_n = q.s2[0] & ~q.s3[0];
		if (enable && (mark_p ^ mark_n))
		begin
			// Two marks of one polarity in a row break the coding.
			d.bpv = q.marked & (mark_p == q.rx_pol); // RQ12
			d.rx_pol = mark_p;
			d.marked = 1'b1;
		end
		if (!enable)
		begin
			d.pos = 1'b0;
			d.neg = 1'b0;
		end
		else if (bit_tick)
		begin
			// Marks alternate polarity, spaces leave the line idle.
			d.pos = tx_bit & ~q.tx_pol; // RQ12
			d.neg = tx_bit & q.tx_pol; // RQ12
			d.tx_pol = q.tx_pol ^ tx_bit;
			// The level is taken at the local tick; with no clock recovery
			// the far end must keep its bit edges away from that instant.
			d.rx_valid = 1'b1;
			d.rx_bit = q.s2[1] | q.s2[0]; // RQ12
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign tx_take  = bit_tick & enable;
	assign rx_bit   = q.rx_bit;
	assign rx_valid = q.rx_valid;
	assign bpv      = q.bpv;
	assign line_pos = q.pos;
	assign line_neg = q.neg;
endmodule // bsle_ami
`default_nettype wire

/* rtl/bsle_top.sv */
// Status blink encoder, link lamp, line port and APB registers of the bridge.
`timescale 1ns/1ps
`default_nettype none
module bsle_top #(
	parameter int unsigned TICK_DIV = bsle_pkg::TICK_CYCLES,
	parameter int unsigned BIT_DIV  = bsle_pkg::BIT_CYCLES
) (
	// Clock and reset.
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// APB slave.
	input  wire bsle_pkg::bsle_apb_req_type apb_req,
	output var  bsle_pkg::bsle_apb_rsp_type apb_rsp,
	// Conditions from bridge logic on this clock.
	input  wire bsle_pkg::bsle_cond_type    cond,
	// Pins from the base unit and the Ethernet transceiver.
	input  wire logic                       cts_pin,
	input  wire logic                       dcd_pin,
	input  wire logic                       link_pin,
	// Line port.
	input  wire logic                       tx_bit,
	output var  logic                       tx_take,
	output var  logic                       rx_bit,
	output var  logic                       rx_valid,
	input  wire logic                       rx_pos_pin,
	input  wire logic                       rx_neg_pin,
	output var  logic                       line_pos,
	output var  logic                       line_neg,
	// Indicators and interrupt.
	output var  logic                       status_led,
	output var  logic                       link_led,
	output var  logic                       irq
);
	import bsle_pkg::*;

	if (TICK_DIV < 2 || BIT_DIV < 2)
	begin : g_div_check
		$error("bsle_top: divider too small");
	end

	////////////////////////////////////////////////////////////////////////
	// The whole state of the block.
	typedef struct packed {
		logic [2:0]       s1;
		logic [2:0]       s2;
		logic             link_prev;
		logic             buf_prev;
		logic [11:2]      pend;
		logic [11:2][3:0] shown;
		bsle_blink_type   st;
		logic [3:0]       code;
		logic [3:0]       blinks;
		logic [7:0]       tmr;
		logic             led;
		logic [1:0]       ctrl;
		logic [9:0]       irq_stat;
		logic [9:0]       irq_mask;
		logic [31:0]      prdata;
	} bsle_top_st_type;

	bsle_top_st_type q, d;

	logic tick;
	logic bit_tick;
	logic bpv;

	////////////////////////////////////////////////////////////////////////
	bsle_tick #(
		.DIV (TICK_DIV)
	) u_ind_tick (
		.clk   (clk),
		.rst_n (rst_n),
		.tick  (tick) // RQ13
	);

	bsle_tick #(
		.DIV (BIT_DIV)
	) u_bit_tick (
		.clk   (clk),
		.rst_n (rst_n),
		.tick  (bit_tick)
	);

	bsle_ami u_ami (
		.clk        (clk),
		.rst_n      (rst_n),
		.bit_tick   (bit_tick),
		.enable     (q.ctrl[CTRL_LINE_EN_BIT]),
		.tx_bit     (tx_bit),
		.tx_take    (tx_take),
		.rx_bit     (rx_bit),
		.rx_valid   (rx_valid),
		.bpv        (bpv),
		.rx_pos_pin (rx_pos_pin),
		.rx_neg_pin (rx_neg_pin),
		.line_pos   (line_pos),
		.line_neg   (line_neg)
	);

	////////////////////////////////////////////////////////////////////////
	// Condition decode, indexed by the blink count that reports it.
	logic [11:2] act;
	logic        cts_ok;
	logic        dcd_ok;
	logic        link_ok;

	always_comb
	begin
		cts_ok  = q.s2[2];
		dcd_ok  = q.s2[1];
		link_ok = q.s2[0];
		act[2]  = cond.mac_empty; // RQ5
		act[3]  = ~(cts_ok & dcd_ok); // RQ6
		act[4]  = cond.buf_sat; // RQ7
		act[5]  = cond.wan_oversize; // RQ8
		act[6]  = cond.wan_misalign; // RQ8
		act[7]  = cond.wan_abort; // RQ8
		act[8]  = cond.wan_bad_crc; // RQ8
		act[9]  = cond.lan_oversize; // RQ9
		act[10] = cond.lan_misalign; // RQ9
		act[11] = cond.lan_bad_crc; // RQ9
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode. Reads are fetched in the setup cycle, so no wait states.
	logic        setup;
	logic        access;
	logic        wr;
	logic        rd_irq;
	logic        mapped;
	logic [9:0]  ev;
	logic [3:0]  best;

	always_comb
	begin
		setup  = apb_req.psel & ~apb_req.penable;
		access = apb_req.psel & apb_req.penable;
		mapped = (apb_req.paddr == ADDR_CTRL) ||
			(apb_req.paddr == ADDR_STATUS) ||
			(apb_req.paddr == ADDR_IRQ_STAT) ||
			(apb_req.paddr == ADDR_IRQ_MASK);
		wr     = access & apb_req.pwrite & mapped;
		rd_irq = access & ~apb_req.pwrite &
			(apb_req.paddr == ADDR_IRQ_STAT);
		ev = '0;
		ev[IRQ_FRAME_LSB +: 7] = act[11:5];
		ev[IRQ_BUF_BIT]  = cond.buf_sat & ~q.buf_prev;
		ev[IRQ_LINK_BIT] = link_ok ^ q.link_prev;
		ev[IRQ_BPV_BIT]  = bpv;
	end

	////////////////////////////////////////////////////////////////////////
	// Highest pending code wins; nothing pending means healthy.
	always_comb
	begin
		best = CODE_OK; // RQ4
		for (int c = 2; c <= 11; c++)
		begin
			if (q.pend[c])
				best = 4'(c); // RQ3
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		d = q;
		d.s1 = {cts_pin, dcd_pin, link_pin};
		d.s2 = q.s1;
		d.link_prev = link_ok;
		d.buf_prev = cond.buf_sat;

		// A live condition restarts its showings; a code drops only when
		// quiet and shown often enough, so a flicker is always seen.
		for (int c = 2; c <= 11; c++)
		begin
			if (act[c])
			begin
				d.pend[c] = 1'b1;
				d.shown[c] = 4'h0;
			end
			else if (q.pend[c] && q.shown[c] >= SHOW_REPEATS)
				d.pend[c] = 1'b0; // RQ10
		end

		case (q.st)
			ST_IDLE:
			begin
				d.led = 1'b0;
				if (q.ctrl[CTRL_LED_EN_BIT] && tick)
				begin
					d.code = best; // RQ3
					d.blinks = 4'h1;
					d.tmr = 8'h00;
					d.led = 1'b1;
					d.st = ST_ON;
				end
			end
			ST_ON:
			begin
				if (tick)
				begin
					if (q.tmr == ON_TICKS - 8'h01)
					begin
						d.tmr = 8'h00;
						d.led = 1'b0;
						if (q.blinks == q.code)
							d.st = ST_GAP; // RQ1
						else
							d.st = ST_OFF; // RQ13
					end
					else
						d.tmr = q.tmr + 8'h01;
				end
			end
			ST_OFF:
			begin
				if (tick)
				begin
					if (q.tmr == OFF_TICKS - 8'h01)
					begin
						d.tmr = 8'h00;
						d.led = 1'b1;
						d.blinks = q.blinks + 4'h1; // RQ1
						d.st = ST_ON;
					end
					else
						d.tmr = q.tmr + 8'h01;
				end
			end
			ST_GAP:
			begin
				if (tick)
				begin
					if (q.tmr == GAP_TICKS - 8'h01)
					begin
						// The showing counts only once its gap is over.
						d.tmr = 8'h00;
						d.st = ST_IDLE; // RQ2
						if (q.code >= CODE_LOWEST && q.code <= CODE_HIGHEST &&
							!act[q.code] && q.shown[q.code] < SHOW_REPEATS)
							d.shown[q.code] = q.shown[q.code] + 4'h1; // RQ10
					end
					else
						d.tmr = q.tmr + 8'h01;
				end
			end
			default:
			begin
				d.st = ST_IDLE;
				d.led = 1'b0;
			end
		endcase

		// Register writes.
		if (wr && apb_req.paddr == ADDR_CTRL)
			d.ctrl = apb_req.pwdata[1:0];
		if (wr && apb_req.paddr == ADDR_IRQ_MASK)
			d.irq_mask = apb_req.pwdata[IRQ_W-1:0];

		// A read clears only the flags it returned, so a flag that lands
		// between the setup and access edges survives; a new event wins.
		d.irq_stat = q.irq_stat | ev;
		if (rd_irq)
			d.irq_stat = (q.irq_stat & ~q.prdata[IRQ_W-1:0]) | ev;

		// Read data captured in the setup cycle, held through access.
		if (setup)
		begin
			d.prdata = 32'h00000000;
			case (apb_req.paddr)
				ADDR_CTRL:
					d.prdata[1:0] = q.ctrl;
				ADDR_STATUS:
				begin
					d.prdata[STAT_CODE_LSB +: 4] = q.code;
					d.prdata[STAT_LINK_BIT] = link_ok;
					d.prdata[STAT_PEND_LSB +: 10] = q.pend;
				end
				ADDR_IRQ_STAT:
					d.prdata[IRQ_W-1:0] = q.irq_stat;
				ADDR_IRQ_MASK:
					d.prdata[IRQ_W-1:0] = q.irq_mask;
				default:
					d.prdata = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.st <= ST_IDLE;
			q.ctrl <= CTRL_RST;
			q.irq_mask <= IRQ_MASK_RST;
		end
		else
			q <= d;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		apb_rsp.pready  = 1'b1;
		apb_rsp.pslverr = access & ~mapped;
		apb_rsp.prdata  = q.prdata;
	end

	assign status_led = q.led; // RQ1
	assign link_led   = q.s2[0]; // RQ11
	assign irq        = |(q.irq_stat & q.irq_mask);
endmodule // bsle_top
`default_nettype wire

/* verification/bsle_checker.sv */
// Port checker of the bridge status encoder, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module bsle_checker
	import bsle_pkg::*;
#(
	parameter int unsigned TICK_DIV = 4,
	parameter int unsigned BIT_DIV  = 4
) (
	// Clock and reset.
	input wire logic                       clk,
	input wire logic                       rst_n,
	// Register bus.
	input wire bsle_pkg::bsle_apb_req_type apb_req,
	input wire bsle_pkg::bsle_apb_rsp_type apb_rsp,
	// Pins and indicators.
	input wire logic                       link_pin,
	input wire logic                       line_pos,
	input wire logic                       line_neg,
	input wire logic                       status_led,
	input wire logic                       link_led,
	input wire logic                       irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	localparam int ON_C  = ON_TICKS * TICK_DIV;
	localparam int OFF_C = OFF_TICKS * TICK_DIV;
	localparam int GAP_C = GAP_TICKS * TICK_DIV;
	logic [1:0] up_q;
	logic       wm_q;
	int         lit_q;
	int         dark_q;
	int         n_q;
	logic       bad;
	assign bad = !(apb_req.paddr inside
		{ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_STAT, ADDR_IRQ_MASK});
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			up_q <= 2'h0;
			wm_q <= 1'b0;
			lit_q <= 0;
			dark_q <= 0;
			n_q <= 0;
		end
		else
		begin
			up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
			wm_q <= wm_q || (apb_req.psel && apb_req.penable
				&& apb_req.pwrite && apb_req.paddr == ADDR_IRQ_MASK);
			lit_q <= status_led ? lit_q + 1 : 0;
			dark_q <= status_led ? 0 : dark_q + 1;
			// A blink that follows a short dark spell belongs to the same burst.
			if (status_led && lit_q == 0)
				n_q <= (dark_q == OFF_C) ? n_q + 1 : 1;
		end
	end
	sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
	sequence s_access; apb_req.psel && apb_req.penable; endsequence
	property p_err; s_setup ##1 s_access |-> apb_rsp.pslverr == bad; endproperty
	a_err: assert property (p_err)
		else $error("slave error does not follow the address");
	property p_rd0;
		s_setup ##1 s_access ##0 (!apb_req.pwrite && bad)
			|-> apb_rsp.prdata == 32'h0;
	endproperty
	a_rd0: assert property (p_rd0)
		else $error("unmapped read returned data");
	property p_irq; !wm_q |-> !irq; endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt raised while all sources masked");
	property p_lit; $fell(status_led) && up_q != 2'h0 |-> lit_q == ON_C;
	endproperty
	a_lit: assert property (p_lit)
		else $error("blink on time wrong");
	property p_dark;
		$rose(status_led) && n_q != 0 |-> dark_q == OFF_C || dark_q >= GAP_C;
	endproperty
	a_dark: assert property (p_dark)
		else $error("dark spell before a blink has a wrong length");
	property p_cnt;
		$rose(status_led) && dark_q == OFF_C |-> n_q inside {[1:10]};
	endproperty
	a_cnt: assert property (p_cnt)
		else $error("burst longer than eleven blinks");
	property p_link; up_q == 2'h3 |-> link_led == $past(link_pin, 2);
	endproperty
	a_link: assert property (p_link)
		else $error("link lamp does not follow the link pin");
	property p_ami; !(line_pos && line_neg); endproperty
	a_ami: assert property (p_ami)
		else $error("both line polarities driven at once");
endmodule // bsle_checker

bind bsle_top bsle_checker #(
	.TICK_DIV(TICK_DIV),
	.BIT_DIV(BIT_DIV)
) u_bsle_checker (
	.clk, .rst_n, .apb_req, .apb_rsp, .link_pin, .line_pos, .line_neg,
	.status_led, .link_led, .irq
);
`default_nettype wire

/* verification/bsle_viewer.sv */
// Behavioural operator who counts the blinks of each status burst.
`timescale 1ns/1ps
`default_nettype none
module bsle_viewer
	import bsle_pkg::*;
#(
	parameter int unsigned TICK_DIV = 4
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Lamp being watched.
	input  wire logic status_led,
	// Burst report.
	output var  logic done,
	output var  int   blinks
);
	// Reporting well before the long gap ends leaves the bench time to act.
	localparam int QUIET = (OFF_TICKS + 5) * TICK_DIV;
	int   dark;
	int   cnt;
	logic was;
	always @(posedge clk)
	begin
		done <= 1'b0;
		was <= status_led;
		dark <= status_led ? 0 : dark + 1;
		if (!rst_n)
			cnt <= 0;
		else if (dark == QUIET && cnt > 0)
		begin
			done <= 1'b1;
			blinks <= cnt;
			cnt <= 0;
		end
		else if (status_led && !was)
			cnt <= cnt + 1;
	end
endmodule // bsle_viewer
`default_nettype wire

/* verification/bsle_top_test.sv */
// Self-checking testbench of the bridge status encoder.
`timescale 1ns/1ps
`default_nettype none
module bsle_top_test;
	import bsle_pkg::*;
	logic             clk, rst_n, cts_pin, dcd_pin, link_pin, tx_bit;
	logic             tx_take, rx_bit, rx_valid, line_pos, line_neg;
	logic             status_led, link_led, irq, done, err, lv, line_on;
	logic [1:0]       txq;
	logic [31:0]      rd;
	bsle_apb_req_type apb_req;
	bsle_apb_rsp_type apb_rsp;
	bsle_cond_type    cond;
	int               mismatches, comparisons, blinks, ex, b, nb, ph, r;
	int               pend[12];
	bsle_top #(.TICK_DIV(4), .BIT_DIV(4)) u_bsle_top (
		.clk, .rst_n, .apb_req, .apb_rsp, .cond, .cts_pin, .dcd_pin,
		.link_pin, .tx_bit, .tx_take, .rx_bit, .rx_valid,
		.rx_pos_pin(line_pos), .rx_neg_pin(line_neg), .line_pos,
		.line_neg, .status_led, .link_led, .irq);
	bsle_viewer #(.TICK_DIV(4)) u_bsle_viewer (
		.clk, .rst_n, .status_led, .done, .blinks);
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
		if (tx_take)
			tx_bit <= 1'($urandom);
	// The loop back is shorter than a bit, so each received bit is the one
	// taken one line bit before; an idle or paused line gives zeros.
	always @(posedge clk)
	begin
		if (rst_n && rx_valid === 1'b1)
			check("line bit", 32'(rx_bit), 32'(txq[1]));
		if (!rst_n || !line_on)
			txq <= 2'h0;
		else if (tx_take === 1'b1)
			txq <= {txq[0], tx_bit};
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do
			@(posedge clk);
		while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge clk);
	endtask
	function automatic int top_code();
		for (int c = 11; c > 1; c--)
			if (pend[c] > 0)
				return c;
		return 1;
	endfunction
	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge clk);
		mismatches++;
		print_verdict();
	end
	initial
	begin
		{mismatches, comparisons, b, ph} = '0;
		{rst_n, link_pin, tx_bit, cts_pin, dcd_pin} = 5'b00011;
		line_on = 1'b1;
		apb_req = '0;
		cond = '0;
		pend = '{default: 0};
		pend[3] = 8;
		r = $urandom(32'h1d63);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl", rd, 32'h3);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		check("irq stat", rd, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped data", rd, 32'h0);
		check("unmapped error", 32'(err), 32'h1);
		r = $urandom;
		apb(1'b1, ADDR_IRQ_MASK, 32'(r));
		apb(1'b0, ADDR_IRQ_MASK, 32'h0);
		check("mask", rd, 32'(r) & 32'h3ff);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0);
		link_pin <= 1'b1;
		repeat (3) @(posedge clk);
		check("link lamp on", 32'(link_led), 32'h1);
		check("masked irq", 32'(irq), 32'h0);
		apb(1'b1, ADDR_IRQ_MASK, 32'h100);
		check("unmasked irq", 32'(irq), 32'h1);
		apb(1'b0, ADDR_IRQ_STAT, 32'h0);
		check("irq flags", rd, 32'h100);
		check("cleared irq", 32'(irq), 32'h0);
		link_pin <= 1'b0;
		repeat (3) @(posedge clk);
		check("link lamp off", 32'(link_led), 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h1);
		line_on = 1'b0;
		apb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl written", rd, 32'h1);
		repeat (8)
		begin
			@(posedge clk);
			check("line off", {tx_take, line_pos, line_neg}, 32'h0);
		end
		line_on = 1'b1;
		apb(1'b1, ADDR_CTRL, 32'h3);
		while (ph < 3)
		begin
			ex = top_code();
			do
				@(posedge clk);
			while (done !== 1'b1);
			check("blinks", blinks, ex);
			apb(1'b0, ADDR_STATUS, 32'h0);
			check("shown code", {28'h0, rd[3:0]}, ex);
			b++;
			if (b == 1)
			begin
				r = 5 + $urandom % 7;
				cond <= 9'h1 << (11 - r);
				@(posedge clk);
				pend[r] = 8;
			end
			else if (ph == 0 && ex == 1)
			begin
				ph = 1;
				nb = b;
			end
			else if (ph == 1 && b == nb + 2)
				ph = 2;
			else if (ph == 2 && ex == 1)
				ph = 3;
			// Stimulus lands in the long gap, so it counts for this showing.
			lv = (ph == 1);
			cond <= {lv, lv, 7'h0};
			if (ex > 1)
				pend[ex]--;
			if (lv)
			begin
				pend[2] = 8;
				pend[4] = 8;
			end
		end
		print_verdict();
	end
endmodule // bsle_top_test
`default_nettype wire
